// file: tmr_defs.vh
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH

// ----------------------------------------------------------------
// Mode select field codes
// ----------------------------------------------------------------
`define TMR_MODE_TIMER     2'b00
`define TMR_MODE_RSVD      2'b01
`define TMR_MODE_DIVIDER   2'b10
`define TMR_MODE_PWM       2'b11

// ----------------------------------------------------------------
// Source clock select codes (prescale of the core clock; EXT takes the event pin in timer mode)
// ----------------------------------------------------------------
`define TMR_SRC_DIV2K      3'b000
`define TMR_SRC_DIV128     3'b001
`define TMR_SRC_DIV32      3'b010
`define TMR_SRC_DIV8       3'b011
`define TMR_SRC_DIV4       3'b100
`define TMR_SRC_DIV2       3'b101
`define TMR_SRC_DIV1       3'b110
`define TMR_SRC_EXT        3'b111

// ----------------------------------------------------------------
// Prescaler tap masks, low bits all ones marks a tick
// ----------------------------------------------------------------
`define TMR_PRE_W          11
`define TMR_MASK_DIV2K     11'h07FF
`define TMR_MASK_DIV128    11'h007F
`define TMR_MASK_DIV32     11'h001F
`define TMR_MASK_DIV8      11'h0007
`define TMR_MASK_DIV4      11'h0003
`define TMR_MASK_DIV2      11'h0001
`define TMR_MASK_DIV1      11'h0000

// ----------------------------------------------------------------
// Counter constants and reset values
// ----------------------------------------------------------------
`define TMR_CNT_ZERO       8'h00
`define TMR_CNT_ONE        8'h01
`define TMR_CNT_TOP        8'hFF
`define TMR_CMP_RESET      8'hFF
`define TMR_PIN_IDLE       1'b1

// ----------------------------------------------------------------
// Event pin minimum phase: 2^3 high frequency clock periods
// ----------------------------------------------------------------
`define TMR_EVT_MIN_FC     8

`endif

// file: tmr_sync.v
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter and edges
// ----------------------------------------------------------------
module tmr_sync (
   input  wire core_clk_in,
   input  wire rst_n_in,
   input  wire clk_en_in,
   input  wire pin_in,
   output reg  level_out,
   output wire rise_out,
   output wire fall_out
);

   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg prev_q;

   // Stage one is read only by stage two; level follows agreed stages
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q      <= 1'b0;
         s2_q      <= 1'b0;
         s3_q      <= 1'b0;
         level_out <= 1'b0;
         prev_q    <= 1'b0;
      end else if (clk_en_in) begin
         s1_q   <= pin_in;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         prev_q <= level_out;
         if (s2_q == s3_q) begin
            level_out <= s3_q;
         end
      end
   end

   // Edges come from the filtered level only
   assign rise_out = level_out & ~prev_q;
   assign fall_out = ~level_out & prev_q;

endmodule // tmr_sync

// file: tmr_prescale.v
`timescale 1ns/10ps
`include "tmr_defs.vh"

// ----------------------------------------------------------------
// Free-running prescaler giving a one-cycle source tick
// ----------------------------------------------------------------
module tmr_prescale (
   input  wire       core_clk_in,
   input  wire       rst_n_in,
   input  wire       clk_en_in,
   input  wire [2:0] select_in,
   output wire       tick_out
);

   reg  [`TMR_PRE_W-1:0] div_q;
   wire [`TMR_PRE_W-1:0] mask;

   // Map a source code to the low bits that must all be ones
   function [`TMR_PRE_W-1:0] tap_mask;
      input [2:0] sel;
      begin
         case (sel)
            `TMR_SRC_DIV2K:  tap_mask = `TMR_MASK_DIV2K;
            `TMR_SRC_DIV128: tap_mask = `TMR_MASK_DIV128;
            `TMR_SRC_DIV32:  tap_mask = `TMR_MASK_DIV32;
            `TMR_SRC_DIV8:   tap_mask = `TMR_MASK_DIV8;
            `TMR_SRC_DIV4:   tap_mask = `TMR_MASK_DIV4;
            `TMR_SRC_DIV2:   tap_mask = `TMR_MASK_DIV2;
            default:         tap_mask = `TMR_MASK_DIV1;
         endcase
      end
   endfunction

   assign mask = tap_mask(select_in);

   // Free running so changing the divisor never needs a restart
   always @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_q <= {`TMR_PRE_W{1'b0}};
      end else if (clk_en_in) begin
         div_q <= div_q + {{(`TMR_PRE_W-1){1'b0}}, 1'b1};
      end
   end

   assign tick_out = clk_en_in && ((div_q & mask) == mask);

endmodule // tmr_prescale

// file: tmr_top.v
`timescale 1ns/10ps
`include "tmr_defs.vh"

module tmr_top #(
   parameter CNT_W = 8
) (
   input  wire             core_clk_in,
   input  wire             reset_n_in,
   input  wire             clk_en_in,
   input  wire             run_control_in,
   input  wire [1:0]       mode_select_in,
   input  wire [2:0]       source_clock_select_in,
   input  wire [CNT_W-1:0] compare_value_in,
   input  wire             compare_write_in,
   input  wire             low_speed_mode_in,
   input  wire             stop_mode_in,
   input  wire             event_input_pin_in,
   output reg              match_interrupt_out,
   output reg              divider_output_pin_out,
   output reg              pwm_output_pin_out,
   output reg  [CNT_W-1:0] counter_out,
   output reg              run_control_out,
   output reg  [CNT_W-1:0] pwm_compare_out
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   reg rst_meta_q;
   reg rst_n_q;

   // Assert at once, release two clocks later so all flops leave together
   always @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Event pin conditioning and source tick
   // ----------------------------------------------------------------
   wire evt_level;
   wire evt_rise;
   wire evt_fall;
   wire src_tick;

   // Three flops and an agreement check give clean edges
   tmr_sync u_sync (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_q),
      .clk_en_in   (clk_en_in),
      .pin_in      (event_input_pin_in),
      .level_out   (evt_level),
      .rise_out    (evt_rise),
      .fall_out    (evt_fall)
   );

   // Internal source clock as a one-cycle enable
   tmr_prescale u_pre (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_q),
      .clk_en_in   (clk_en_in),
      .select_in   (source_clock_select_in),
      .tick_out    (src_tick)
   );

   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   reg run_req_q;
   reg stop_q;
   wire run_rise;
   wire stop_entry;

   assign run_rise   = run_control_in & ~run_req_q;
   assign stop_entry = stop_mode_in & ~stop_q;

   // Start on the request edge; stop entry wins over a start
   always @(posedge core_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         run_req_q       <= 1'b0;
         stop_q          <= 1'b0;
         run_control_out <= 1'b0;
      end else if (clk_en_in) begin
         run_req_q <= run_control_in;
         stop_q    <= stop_mode_in;
         if (stop_entry) begin
            run_control_out <= 1'b0;
         end else if (run_rise) begin
            run_control_out <= 1'b1;
         end else if (!run_control_in) begin
            run_control_out <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   wire is_timer;
   wire is_div;
   wire is_pwm;
   wire ext_src;
   wire evt_mode;
   wire pwm_ok;
   wire evt_ok;

   assign is_timer = (mode_select_in == `TMR_MODE_TIMER);
   assign is_div   = (mode_select_in == `TMR_MODE_DIVIDER);
   assign is_pwm   = (mode_select_in == `TMR_MODE_PWM);
   assign ext_src  = (source_clock_select_in == `TMR_SRC_EXT);
   assign evt_mode = is_timer & ext_src;

   // Low speed mode alone cuts off event pin counting and the PWM output
   assign evt_ok = ~low_speed_mode_in;
   assign pwm_ok = ~low_speed_mode_in;

   // ----------------------------------------------------------------
   // Counter, match and outputs
   // ----------------------------------------------------------------
   reg  [CNT_W-1:0] cnt_d;
   reg  [CNT_W-1:0] shadow_q;
   reg  [CNT_W-1:0] shadow_d;
   reg  [CNT_W-1:0] act_d;
   reg              irq_d;
   reg              div_d;
   reg              pwm_d;
   wire [CNT_W-1:0] cnt_inc;
   wire             cnt_top;
   wire             running;

   assign cnt_inc = counter_out + {{(CNT_W-1){1'b0}}, 1'b1};
   assign cnt_top = (counter_out == {CNT_W{1'b1}});
   assign running = run_control_out;

   // Shadow stage catches software writes at any time
   always @* begin
      shadow_d = shadow_q;
      if (compare_write_in) begin
         shadow_d = compare_value_in;
      end
   end

   // Next-state logic for all modes; reserved mode stays idle
   always @* begin
      cnt_d = counter_out;
      act_d = pwm_compare_out;
      irq_d = 1'b0;
      div_d = divider_output_pin_out;
      pwm_d = pwm_output_pin_out;
      if (!running) begin
         // Stopped: counter clear, pins parked high
         cnt_d = {CNT_W{1'b0}};
         div_d = `TMR_PIN_IDLE;
         pwm_d = `TMR_PIN_IDLE;
         if (run_rise && !stop_entry) begin
            act_d = shadow_d;
         end
      end else if (evt_mode) begin
         if (evt_ok) begin
            // Count on rising edge, judge the match on the falling one
            if (evt_rise) begin
               cnt_d = cnt_inc;
            end else if (evt_fall && counter_out == compare_value_in) begin
               irq_d = 1'b1;
               cnt_d = {CNT_W{1'b0}};
            end
         end
      end else if (is_timer) begin
         if (src_tick) begin
            if (cnt_inc == compare_value_in) begin
               irq_d = 1'b1;
               cnt_d = {CNT_W{1'b0}};
            end else begin
               cnt_d = cnt_inc;
            end
         end
      end else if (is_div) begin
         // Equal half periods: one compare span per level
         if (src_tick) begin
            if (cnt_inc == compare_value_in) begin
               div_d = ~divider_output_pin_out;
               irq_d = 1'b1;
               cnt_d = {CNT_W{1'b0}};
            end else begin
               cnt_d = cnt_inc;
            end
         end
      end else if (is_pwm) begin
         if (!pwm_ok) begin
            pwm_d = `TMR_PIN_IDLE;
         end else if (src_tick) begin
            // Full eight-bit wrap per period, never cleared by match
            cnt_d = cnt_inc;
            if (cnt_top) begin
               pwm_d = 1'b1;
               irq_d = 1'b1;
               act_d = shadow_d;
            end else if (cnt_inc == pwm_compare_out) begin
               pwm_d = 1'b0;
            end
         end
      end
   end

   // State registers, all frozen while the clock enable is low
   always @(posedge core_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         counter_out            <= `TMR_CNT_ZERO;
         shadow_q               <= `TMR_CMP_RESET;
         pwm_compare_out        <= `TMR_CMP_RESET;
         match_interrupt_out    <= 1'b0;
         divider_output_pin_out <= `TMR_PIN_IDLE;
         pwm_output_pin_out     <= `TMR_PIN_IDLE;
      end else if (clk_en_in) begin
         counter_out            <= cnt_d;
         shadow_q               <= shadow_d;
         pwm_compare_out        <= act_d;
         match_interrupt_out    <= irq_d;
         divider_output_pin_out <= div_d;
         pwm_output_pin_out     <= pwm_d;
      end
   end

endmodule // tmr_top

// file: tmr_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port checker for the timer block
// ----------------------------------------------------------------
module tmr_assertions #(
   parameter CNT_W = 8
) (
   input wire             core_clk_in,
   input wire             reset_n_in,
   input wire [1:0]       mode_select_in,
   input wire [2:0]       source_clock_select_in,
   input wire             low_speed_mode_in,
   input wire             stop_mode_in,
   input wire             event_input_pin_in,
   input wire             match_interrupt_out,
   input wire             divider_output_pin_out,
   input wire             pwm_output_pin_out,
   input wire [CNT_W-1:0] counter_out,
   input wire             run_control_out,
   input wire [CNT_W-1:0] pwm_compare_out
);
   default clocking dc @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   // Running for two samples, so start and stop edges are skipped
   sequence s_running;
      run_control_out && $past(run_control_out);
   endsequence
   sequence s_parked;
      low_speed_mode_in && $past(low_speed_mode_in);
   endsequence
   a_div_stop_high: assert property (
      !run_control_out && !$past(run_control_out) |->
      divider_output_pin_out)
      else $error("divider pin low while stopped");
   a_pwm_stop_high: assert property (
      !run_control_out && !$past(run_control_out) |->
      pwm_output_pin_out)
      else $error("pwm pin low while stopped");
   a_div_toggle_irq: assert property (
      s_running ##0 mode_select_in == 2'b10 |->
      (divider_output_pin_out != $past(divider_output_pin_out)) ==
      match_interrupt_out)
      else $error("divider toggle and interrupt disagree");
   a_match_clears: assert property (
      match_interrupt_out && mode_select_in != 2'b11 |->
      counter_out == 8'h00)
      else $error("counter not cleared on match");
   a_pwm_wrap_high: assert property (
      match_interrupt_out && mode_select_in == 2'b11 |->
      pwm_output_pin_out && counter_out == 8'h00)
      else $error("pwm wrap without high pin");
   a_pwm_duty_cmp: assert property (
      s_running ##0 mode_select_in == 2'b11 && !low_speed_mode_in &&
      !$past(low_speed_mode_in) |->
      pwm_output_pin_out == (pwm_compare_out == 8'h00 ||
      counter_out < pwm_compare_out))
      else $error("pwm level disagrees with compare");
   a_stop_clears: assert property (
      $rose(stop_mode_in) |=> !run_control_out)
      else $error("stop entry left timer running");
   // Only while running: a stop legally clears the counter when parked
   a_event_frozen: assert property (
      s_running ##0 s_parked ##0 mode_select_in == 2'b00 &&
      source_clock_select_in == 3'b111 |-> $stable(counter_out))
      else $error("event counted in low speed");
   a_event_fall: assert property (
      match_interrupt_out && mode_select_in == 2'b00 &&
      source_clock_select_in == 3'b111 |->
      !event_input_pin_in && !$past(event_input_pin_in, 3))
      else $error("event match off the falling edge");
   a_pwm_parked: assert property (
      s_parked ##0 mode_select_in == 2'b11 |-> pwm_output_pin_out)
      else $error("pwm active in low speed");
endmodule // tmr_assertions

bind tmr_top tmr_assertions #(.CNT_W(CNT_W)) u_chk (
   .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
   .mode_select_in(mode_select_in),
   .source_clock_select_in(source_clock_select_in),
   .low_speed_mode_in(low_speed_mode_in), .stop_mode_in(stop_mode_in),
   .event_input_pin_in(event_input_pin_in),
   .match_interrupt_out(match_interrupt_out),
   .divider_output_pin_out(divider_output_pin_out),
   .pwm_output_pin_out(pwm_output_pin_out), .counter_out(counter_out),
   .run_control_out(run_control_out), .pwm_compare_out(pwm_compare_out));

// file: tmr_evt_src.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// External pulse source for the event pin
// ----------------------------------------------------------------
module tmr_evt_src #(
   parameter HALF = 10
) (
   input  wire       clk_in,
   input  wire       start_in,
   input  wire [3:0] pulses_in,
   output reg        pin_out = 1'b0,
   output reg        busy_out = 1'b0
);
   reg [4:0] edges_q = 5'h00;
   reg [7:0] cnt_q   = 8'h00;
   // Each phase held HALF cycles, above the eight-clock minimum
   always @(posedge clk_in) begin
      if (start_in && !busy_out) begin
         edges_q  <= {pulses_in, 1'b0};
         cnt_q    <= 8'h00;
         busy_out <= 1'b1;
      end else if (busy_out) begin
         if (cnt_q == HALF - 1) begin
            cnt_q   <= 8'h00;
            pin_out <= ~pin_out;
            edges_q <= edges_q - 5'h01;
            if (edges_q == 5'h01)
               busy_out <= 1'b0;
         end else
            cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule // tmr_evt_src

// file: tmr_top_tb.sv
`timescale 1ns/10ps
module tmr_top_tb;
   reg        clk = 1'b0;
   reg        rst_n = 1'b0;
   reg        run = 1'b0;
   reg  [1:0] mode = 2'b00;
   reg  [2:0] sel = 3'b110;
   reg  [7:0] cmp = 8'h03;
   reg        cwr = 1'b0;
   reg        lows = 1'b0;
   reg        stopm = 1'b0;
   reg        go = 1'b0;
   reg  [3:0] npls = 4'h0;
   wire       evt, busy, irq, div, pwm, run_o;
   wire [7:0] cnt, pcmp;
   integer    miscompares = 0;
   integer    samples_checked = 0;
   integer    irqs = 0;
   integer    n, hi, i, k;
   tmr_top DUT (.core_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1),
      .run_control_in(run), .mode_select_in(mode),
      .source_clock_select_in(sel), .compare_value_in(cmp),
      .compare_write_in(cwr), .low_speed_mode_in(lows),
      .stop_mode_in(stopm), .event_input_pin_in(evt),
      .match_interrupt_out(irq), .divider_output_pin_out(div),
      .pwm_output_pin_out(pwm), .counter_out(cnt),
      .run_control_out(run_o), .pwm_compare_out(pcmp));
   tmr_evt_src u_src (.clk_in(clk), .start_in(go), .pulses_in(npls),
      .pin_out(evt), .busy_out(busy));
   // ----------------------------------------------------------------
   // Clock, interrupt tally and helpers
   // ----------------------------------------------------------------
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
   task check(input string name, input [8:0] seen, input [8:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("BAD %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task cyc(input integer c);
      repeat (c) @(negedge clk);
   endtask
   task do_reset;
      @(posedge clk) rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task start(input [1:0] m, input [2:0] s, input [7:0] c);
      @(posedge clk) mode <= m;
      sel <= s;
      cmp <= c;
      repeat (2) @(posedge clk);
      run <= 1'b1;
      cyc(2);
   endtask
   // Run flop drops one edge after the request, the pins one edge later
   task halt;
      @(posedge clk) run <= 1'b0;
      cyc(3);
   endtask
   // Cycles to the next interrupt, pwm high cycles summed on the way
   task wait_irq(output integer t);
      integer w;
      w = irqs;
      t = 0;
      hi = 0;
      while (irqs == w && t < 2000) begin
         @(negedge clk);
         t = t + 1;
         hi = hi + pwm;
      end
      check("irq seen", t < 2000, 1);
   endtask
   task pulse(input [3:0] p);
      @(posedge clk) npls <= p;
      go <= 1'b1;
      @(posedge clk) go <= 1'b0;
      k = 0;
      cyc(1);
      while (busy && k < 500) begin
         cyc(1);
         k = k + 1;
      end
      check("src done", k < 500, 1);
      cyc(8);
   endtask
   task finish_test;
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #400000;
      miscompares = miscompares + 1;
      finish_test;
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      do_reset;
      for (i = 0; i < 2; i = i + 1) begin
         start(2'b10, i ? 3'b001 : 3'b110, i ? 8'h02 : 8'h03);
         wait_irq(n);
         check("div low", div, 0);
         wait_irq(n);
         check("div half", n, i ? 256 : 3);
         check("div high", div, 1);
         wait_irq(n);
         halt;
         check("div stopped", div, 1);
         $display("divider test %0d done", i);
      end
      start(2'b00, 3'b111, 8'h03);
      n = irqs;
      pulse(4'h2);
      check("evt count", cnt, 2);
      check("evt no irq", irqs - n, 0);
      pulse(4'h1);
      check("evt irq", irqs - n, 1);
      check("evt clear", cnt, 0);
      @(posedge clk) lows <= 1'b1;
      pulse(4'h1);
      check("evt frozen", cnt, 0);
      @(posedge clk) lows <= 1'b0;
      halt;
      $display("event test done");
      // Plain timer on the fast source, then the reserved code must idle
      start(2'b00, 3'b110, 8'h05);
      wait_irq(n);
      wait_irq(n);
      check("timer span", n, 5);
      halt;
      start(2'b01, 3'b110, 8'h05);
      cyc(20);
      check("rsvd idle", cnt, 0);
      halt;
      $display("timer test done");
      do_reset;
      @(posedge clk) cmp <= 8'h40;
      cwr <= 1'b1;
      @(posedge clk) cwr <= 1'b0;
      start(2'b11, 3'b110, 8'h40);
      check("pwm first", pcmp, 9'h040);
      // Rewrite mid-cycle, well clear of the wrap interrupt
      @(posedge clk) cmp <= 8'h80;
      cwr <= 1'b1;
      @(posedge clk) cwr <= 1'b0;
      cyc(2);
      check("pwm held", pcmp, 9'h040);
      wait_irq(n);
      check("pwm shifted", pcmp, 9'h080);
      wait_irq(n);
      check("pwm period", n, 256);
      check("pwm duty", hi, 9'h080);
      // Move into the low phase first so parking high is visible
      cyc(150);
      check("pwm low", pwm, 0);
      @(posedge clk) stopm <= 1'b1;
      cyc(3);
      check("stop run", run_o, 0);
      check("pwm stopped", pwm, 1);
      @(posedge clk) stopm <= 1'b0;
      run <= 1'b0;
      start(2'b11, 3'b110, 8'h80);
      cyc(150);
      check("pwm low again", pwm, 0);
      @(posedge clk) lows <= 1'b1;
      cyc(3);
      check("pwm parked", pwm, 1);
      $display("pwm test done");
      finish_test;
   end
endmodule // tmr_top_tb
